// >>> rtl/comp_b_regs.vh
// Register map, field positions, reset values and mode codes of comparator B.
`ifndef COMP_B_REGS_VH
`define COMP_B_REGS_VH
// ==========================================================================
// Register indices and byte addresses
`define CTRL_B_INDEX 12'h0AB
`define CTRL_B_ADDR 12'h2AC
`define REF_CTRL_INDEX 12'h0BD
`define REF_CTRL_ADDR 12'h2F4
`define IRQ_MASK_ADDR 12'h300
`define IRQ_STATUS_ADDR 12'h304
// ==========================================================================
// Reset values
`define CTRL_B_RESET 8'hC0
`define REF_CTRL_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
// ==========================================================================
// Control register B fields
`define CB_CHAN_HI 7
`define CB_CHAN_LO 6
`define CB_CONNECT 5
`define CB_FLAG 4
`define CB_ENABLE 3
`define CB_MODE_HI 2
`define CB_MODE_LO 0
// ==========================================================================
// Reference control register fields
`define RC_OUT_B 7
`define RC_OUT_A 6
`define RC_REFB_HI 5
`define RC_REFB_LO 4
`define RC_SAMPLE_HI 3
`define RC_SAMPLE_LO 2
`define RC_REFA_HI 1
`define RC_REFA_LO 0
`define RC_WRITE_MASK 8'h3F
// ==========================================================================
// Interrupt mask bit and status bit
`define MASK_COMP_B 6
`define ST_FLAG_B 0
// ==========================================================================
// Event modes
`define MODE_LOW 3'h0
`define MODE_RISE 3'h1
`define MODE_DB_TOGGLE 3'h2
`define MODE_DB_RISE 3'h3
`define MODE_FALL 3'h4
`define MODE_TOGGLE 3'h5
`define MODE_DB_FALL 3'h6
`define MODE_HIGH 3'h7
// ==========================================================================
// Sample strobe selects
`define SAMPLE_SYSCLK 2'h0
`define SAMPLE_T0 2'h1
`define SAMPLE_T1 2'h2
`define SAMPLE_T2 2'h3
// ==========================================================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/pin_sync3.v
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous level in, settled level out
  input wire async_in,
  output reg sync_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // ==========================================================================
  // Stage one feeds stage two only; the agreement check filters a late settle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        sync_out <= s3_reg;
      end
    end
  end
endmodule // pin_sync3
`default_nettype wire

// >>> rtl/comp_event_detect.v
// Level, edge, toggle and debounced event detection for one comparator.
`timescale 1ns/1ns
`default_nettype none
`include "comp_b_regs.vh"
module comp_event_detect (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Configuration
  input wire enable,
  input wire [2:0] mode,
  // Strobes
  input wire sample_stb,
  input wire debounce_tick,
  // Comparator level, already synchronised
  input wire level_in,
  // One-cycle event pulse
  output reg event_pulse
);
  reg prev_reg;
  reg pending_reg;
  reg pend_val_reg;
  wire cur;
  wire rise;
  wire fall;
  wire db_mode;
  reg want;
  reg want_db;
  assign cur = level_in & enable;
  assign rise = cur & ~prev_reg;
  assign fall = ~cur & prev_reg;
  assign db_mode = (mode == `MODE_DB_TOGGLE) || (mode == `MODE_DB_RISE) ||
    (mode == `MODE_DB_FALL);
  // ==========================================================================
  // Mode decode
  always @* begin
    want = 1'b0;
    want_db = 1'b0;
    case (mode)
      `MODE_LOW: want = ~cur;
      `MODE_RISE: want = rise;
      `MODE_DB_TOGGLE: want_db = rise | fall;
      `MODE_DB_RISE: want_db = rise;
      `MODE_FALL: want = fall;
      `MODE_TOGGLE: want = rise | fall;
      `MODE_DB_FALL: want_db = fall;
      default: want = cur;
    endcase
  end
  // ==========================================================================
  // A debounced change is confirmed only if it still stands at the next
  // timer 1 overflow, so a glitch shorter than that delay is dropped.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      pending_reg <= 1'b0;
      pend_val_reg <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= 1'b0;
      if (!enable || !db_mode) begin
        pending_reg <= 1'b0;
      end else if (pending_reg && debounce_tick) begin
        pending_reg <= 1'b0;
        event_pulse <= (cur == pend_val_reg);
      end else if (sample_stb && want_db) begin
        pending_reg <= 1'b1;
        pend_val_reg <= cur;
      end
      if (sample_stb) begin
        prev_reg <= cur;
        if (enable && want) begin
          event_pulse <= 1'b1;
        end
      end
    end
  end
endmodule // comp_event_detect
`default_nettype wire

// >>> rtl/comp_b_ctrl.v
// Comparator B control, event flag, reference control and AXI4-Lite slave.
//
// Behaviour
// - The event flag is set when the output meets the selected mode and the enable is set.
// - Hardware never clears the event flag; only software writes clear it.
// - The interrupt reaches the processor only while mask bit 6 is set.
// - With the enable clear the output is held low and no event sets the flag.
// - With the enable set the digital buffers of all four analog pins are off, whichever channel is selected.
// - Mode codes 0 to 7 select low, rise, debounced toggle, debounced rise, fall, toggle, debounced fall, high.
// - Debounced modes take their sampling delay from timer 1 overflow.
// - The reference control register is eight bits at index BD and resets to zero.
// - Its two top bits read the comparator outputs sampled by the clock; bit 7 (B) reads zero while the enable is clear.
// - The sample clock select picks system clock or timer 0, 1 or 2 overflow.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "comp_b_regs.vh"
module comp_b_ctrl (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Analog comparator raw outputs, asynchronous
  input wire cmp_raw_a,
  input wire cmp_raw_b,
  // Timer overflow pulses on this clock
  input wire timer0_ovf,
  input wire timer1_ovf,
  input wire timer2_ovf,
  // Analog front-end controls
  output reg input_connect_b,
  output reg [1:0] positive_channel_select_b,
  output reg [1:0] negative_reference_select_b,
  output reg [1:0] negative_reference_select_a,
  output reg [3:0] digital_input_disable,
  output reg comparator_out_b,
  // Interrupt
  output reg irq
);
  reg [7:0] ctrl_b_reg;
  reg [7:0] ctrl_b_next;
  reg [5:0] ref_ctrl_reg;
  reg [7:0] irq_mask_reg;
  reg [11:0] aw_addr_reg;
  reg aw_full_reg;
  reg [7:0] w_data_reg;
  reg w_strb_reg;
  reg w_full_reg;
  reg [7:0] rd_val;
  reg rd_hit;
  reg wr_hit;
  wire sync_a;
  wire sync_b;
  wire event_b;
  wire do_write;
  wire [1:0] sample_sel;
  wire [7:0] ref_ctrl_view;
  reg sample_stb;
  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign sample_sel = ref_ctrl_reg[`RC_SAMPLE_HI:`RC_SAMPLE_LO];
  assign ref_ctrl_view = {sync_b & ctrl_b_reg[`CB_ENABLE], sync_a,
    ref_ctrl_reg};
  // ==========================================================================
  // Comparator input capture and event detection
  pin_sync3 u_sync_a (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(cmp_raw_a),
    .sync_out(sync_a)
  );
  pin_sync3 u_sync_b (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(cmp_raw_b),
    .sync_out(sync_b)
  );
  always @* begin
    case (sample_sel)
      `SAMPLE_SYSCLK: sample_stb = 1'b1;
      `SAMPLE_T0: sample_stb = timer0_ovf;
      `SAMPLE_T1: sample_stb = timer1_ovf;
      default: sample_stb = timer2_ovf;
    endcase
  end
  comp_event_detect u_detect_b (
    .clk(clk),
    .rst_n(rst_n),
    .enable(ctrl_b_reg[`CB_ENABLE]),
    .mode(ctrl_b_reg[`CB_MODE_HI:`CB_MODE_LO]),
    .sample_stb(sample_stb),
    .debounce_tick(timer1_ovf),
    .level_in(sync_b),
    .event_pulse(event_b)
  );
  // ==========================================================================
  // Write decode; a flag set by an event wins over a clear in the same cycle.
  always @* begin
    ctrl_b_next = ctrl_b_reg;
    wr_hit = 1'b0;
    if (aw_addr_reg == `CTRL_B_ADDR) begin
      wr_hit = 1'b1;
      if (do_write && w_strb_reg) begin
        ctrl_b_next = w_data_reg;
      end
    end else if (aw_addr_reg == `REF_CTRL_ADDR) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `IRQ_MASK_ADDR) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `IRQ_STATUS_ADDR) begin
      wr_hit = 1'b1;
      if (do_write && w_strb_reg && w_data_reg[`ST_FLAG_B]) begin
        ctrl_b_next[`CB_FLAG] = 1'b0;
      end
    end
    if (event_b && ctrl_b_reg[`CB_ENABLE]) begin
      ctrl_b_next[`CB_FLAG] = 1'b1;
    end
  end
  // ==========================================================================
  // Registers and write channel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_b_reg <= `CTRL_B_RESET;
      ref_ctrl_reg <= 6'h00;
      irq_mask_reg <= `IRQ_MASK_RESET;
      aw_addr_reg <= 12'h000;
      aw_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      ctrl_b_reg <= ctrl_b_next;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (w_strb_reg && aw_addr_reg == `REF_CTRL_ADDR) begin
          ref_ctrl_reg <= w_data_reg[5:0];
        end
        if (w_strb_reg && aw_addr_reg == `IRQ_MASK_ADDR) begin
          irq_mask_reg <= w_data_reg;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================================================
  // Read decode
  always @* begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr == `CTRL_B_ADDR) begin
      rd_val = ctrl_b_reg;
    end else if (s_axi_araddr == `REF_CTRL_ADDR) begin
      rd_val = ref_ctrl_view;
    end else if (s_axi_araddr == `IRQ_MASK_ADDR) begin
      rd_val = irq_mask_reg;
    end else if (s_axi_araddr == `IRQ_STATUS_ADDR) begin
      rd_val = {7'h00, ctrl_b_reg[`CB_FLAG]};
    end else begin
      rd_hit = 1'b0;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ==========================================================================
  // Outputs to the analog front end and the interrupt controller.
  // Selects pass straight through; the connect bit guarding them is
  // software's duty, so no interlock is built here.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_connect_b <= 1'b0;
      positive_channel_select_b <= 2'h0;
      negative_reference_select_b <= 2'h0;
      negative_reference_select_a <= 2'h0;
      digital_input_disable <= 4'h0;
      comparator_out_b <= 1'b0;
      irq <= 1'b0;
    end else begin
      input_connect_b <= ctrl_b_reg[`CB_CONNECT];
      positive_channel_select_b <= ctrl_b_reg[`CB_CHAN_HI:`CB_CHAN_LO];
      negative_reference_select_b <= ref_ctrl_reg[`RC_REFB_HI:`RC_REFB_LO];
      negative_reference_select_a <= ref_ctrl_reg[`RC_REFA_HI:`RC_REFA_LO];
      digital_input_disable <= {4{ctrl_b_reg[`CB_ENABLE]}};
      comparator_out_b <= sync_b & ctrl_b_reg[`CB_ENABLE];
      irq <= ctrl_b_reg[`CB_FLAG] & irq_mask_reg[`MASK_COMP_B];
    end
  end
endmodule // comp_b_ctrl
`default_nettype wire

// >>> verif/comp_b_ctrl_asserts.sv
// Port-level assertions for the comparator B control block.
`timescale 1ns/1ns
`default_nettype none
module comp_b_ctrl_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Front-end controls and interrupt
  input wire logic input_connect_b,
  input wire logic [1:0] negative_reference_select_b,
  input wire logic [3:0] digital_input_disable,
  input wire logic comparator_out_b,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  AST_DID_UNIFORM: assert property (
    digital_input_disable == 4'h0 || digital_input_disable == 4'hF)
    else $error("Pin buffer disables disagree.");
  // Two quiet cycles of the enable give slack for the output flop.
  AST_OUT_LOW_OFF: assert property (
    !digital_input_disable[0] && !$past(digital_input_disable[0])
    |-> !comparator_out_b) else $error("Output high while disabled.");
  AST_IRQ_STICKY: assert property (
    $fell(irq) |-> $past(s_axi_bvalid))
    else $error("Interrupt dropped without a write.");
  AST_CTRL_BY_WRITE: assert property (
    $changed({input_connect_b, negative_reference_select_b})
    |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("Control output moved without a write.");
  AST_RDATA_BYTE: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Read data above the low byte.");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  AST_READ_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer not held.");
  AST_WRITE_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("Write answer late.");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer not held.");
endmodule // comp_b_ctrl_asserts
bind comp_b_ctrl comp_b_ctrl_asserts chk_u (.*);
`default_nettype wire

// >>> verif/comp_b_ctrl_test.sv
// Self-checking bench for the comparator B control block.
`timescale 1ns/1ns
`default_nettype none
`include "comp_b_regs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module comp_b_ctrl_test;
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic cmp_raw_a = 0, cmp_raw_b = 0;
  logic timer0_ovf = 0, timer1_ovf = 0, timer2_ovf = 0;
  logic [3:0] tcnt = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, input_connect_b, comparator_out_b, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, positive_channel_select_b;
  logic [1:0] negative_reference_select_b, negative_reference_select_a;
  logic [3:0] digital_input_disable;
  logic [31:0] s_axi_rdata;
  int fails = 0, checks = 0;
  comp_b_ctrl dut_u (.*);
  always #5 clk = ~clk;
  // Timer overflows every 4, 8 and 16 cycles exercise every sample select.
  always @(posedge clk) begin
    tcnt <= tcnt + 4'h1;
    timer0_ovf <= tcnt[1:0] == 2'h0;
    timer1_ovf <= tcnt[2:0] == 3'h3;
    timer2_ovf <= tcnt == 4'h5;
  end
  // ==========================================================================
  // Bus tasks
  task automatic test_done;
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) begin
      fails++;
      test_done();
    end
    `CHK("write response", er, s_axi_bresp)
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er,
                    output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) begin
      fails++;
      test_done();
    end
    d = s_axi_rdata[7:0];
    `CHK("read response", er, s_axi_rresp)
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, `RESP_OKAY, d);
    `CHK("read data", e, d)
  endtask
  // ==========================================================================
  // Scenarios
  task automatic reset_values;
    logic [7:0] d;
    rc(`CTRL_B_ADDR, `CTRL_B_RESET);
    rc(`REF_CTRL_ADDR, `REF_CTRL_RESET);
    rc(`IRQ_MASK_ADDR, `IRQ_MASK_RESET);
    rc(`IRQ_STATUS_ADDR, 8'h00);
    rd(12'h010, `RESP_SLVERR, d);
  endtask
  task automatic ref_fields;
    cmp_raw_a <= 1'b1;
    wr(`REF_CTRL_ADDR, 8'hFF, `RESP_OKAY);
    wr(12'h3F0, 8'h00, `RESP_SLVERR);
    rc(`REF_CTRL_ADDR, 8'h7F);
    `CHK("reference b", 2'h3, negative_reference_select_b)
    `CHK("reference a", 2'h3, negative_reference_select_a)
  endtask
  task automatic connect_order;
    wr(`CTRL_B_ADDR, 8'h87, `RESP_OKAY);
    wr(`CTRL_B_ADDR, 8'hA7, `RESP_OKAY);
    rc(`CTRL_B_ADDR, 8'hA7);
    `CHK("channel select", 2'h2, positive_channel_select_b)
    `CHK("input connect", 1'b1, input_connect_b)
    wr(`CTRL_B_ADDR, 8'h87, `RESP_OKAY);
  endtask
  task automatic edge_step(input int m, input logic lvl, input logic e);
    logic [7:0] d;
    wr(`CTRL_B_ADDR, {5'h01, m[2:0]}, `RESP_OKAY);
    cmp_raw_b <= lvl;
    // Long enough for sync, the slowest strobe and a debounce tick.
    repeat (40) @(posedge clk);
    rd(`CTRL_B_ADDR, `RESP_OKAY, d);
    `CHK("event flag", e, d[4])
    `CHK("interrupt", e, irq)
    `CHK("comparator output", lvl, comparator_out_b)
    `CHK("pin disables", 4'hF, digital_input_disable)
  endtask
  task automatic modes;
    logic [7:0] rise_exp;
    logic [7:0] fall_exp;
    rise_exp = 8'hAF;
    fall_exp = 8'hF5;
    wr(`IRQ_MASK_ADDR, 8'h40, `RESP_OKAY);
    for (int m = 0; m < 8; m++) begin
      wr(`REF_CTRL_ADDR, {4'h0, m[1:0], 2'h0}, `RESP_OKAY);
      wr(`CTRL_B_ADDR, {5'h01, m[2:0]}, `RESP_OKAY);
      repeat (20) @(posedge clk);
      edge_step(m, 1'b1, rise_exp[m]);
      edge_step(m, 1'b0, fall_exp[m]);
    end
  endtask
  task automatic mask_and_disable;
    wr(`CTRL_B_ADDR, 8'h17, `RESP_OKAY);
    cmp_raw_b <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("comparator output", 1'b0, comparator_out_b)
    `CHK("pin disables", 4'h0, digital_input_disable)
    `CHK("interrupt", 1'b1, irq)
    wr(`IRQ_MASK_ADDR, 8'h00, `RESP_OKAY);
    rc(`IRQ_STATUS_ADDR, 8'h01);
    `CHK("interrupt", 1'b0, irq)
    wr(`IRQ_STATUS_ADDR, 8'h01, `RESP_OKAY);
    repeat (40) @(posedge clk);
    rc(`CTRL_B_ADDR, 8'h07);
    rc(`REF_CTRL_ADDR, 8'h4C);
  endtask
  task automatic late_answer;
    int n;
    s_axi_wstrb <= 4'h0;
    wr(`IRQ_MASK_ADDR, 8'hFF, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rc(`IRQ_MASK_ADDR, 8'h00);
    // A slow master leaves each answer waiting; it must stand until taken.
    @(posedge clk);
    s_axi_awaddr <= `IRQ_MASK_ADDR;
    s_axi_wdata <= 32'h00000040;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      test_done();
    end
    repeat (2) @(posedge clk);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    `CHK("held write answer", 1'b1, s_axi_bvalid)
    @(posedge clk);
    s_axi_araddr <= `IRQ_MASK_ADDR;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      test_done();
    end
    repeat (2) @(posedge clk);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    `CHK("held read answer", 1'b1, s_axi_rvalid)
    `CHK("held read data", 32'h00000040, s_axi_rdata)
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    ref_fields();
    connect_order();
    modes();
    mask_and_disable();
    late_answer();
    test_done();
  end
endmodule // comp_b_ctrl_test
`default_nettype wire
